// ### hdl/tis_pkg.sv
// Purpose: shared constants and types for the trap and interrupt sequencer
// Assumes: 100 MHz clk_i, classic Wishbone register access
// Notes: one sequence step lasts one master period from the divider
package tis_pkg;

    // clock and master period timing
    localparam real CLK_NS = 10.0;
    localparam real MASTER_PERIOD_NS = 237.5;
    localparam real DRY_NORM_NS = 237.5;
    localparam real DRY_OUT_NS = 170.0;
    localparam int PER_CYC = int'($floor(MASTER_PERIOD_NS / CLK_NS));
    localparam int DRY_NORM_CYC = int'($ceil(DRY_NORM_NS / CLK_NS));
    localparam int DRY_OUT_CYC = int'($ceil(DRY_OUT_NS / CLK_NS));

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_LADDR = 8'h0c;
    localparam logic [7:0] REG_WDATA = 8'h10;
    localparam logic [7:0] REG_IADDR = 8'h14;

    // control register fields
    localparam int CTL_HALT = 0;
    localparam int CTL_STEP = 1;
    localparam int CTL_JUMP = 2;
    localparam int CTL_IO = 3;
    localparam int CTL_INCM = 4;
    localparam int CTL_SHIFT = 5;
    localparam int CTL_EXTC = 6;
    localparam int CTL_CODE_LSB = 8;
    localparam logic [15:0] CTRL_MASK = 16'h077f;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [14:0] IADDR_RESET = 15'h0000;

    // command register fields
    localparam int CMD_FETCH = 0;
    localparam int CMD_DOUBLE = 1;
    localparam int CMD_JUMP_AND_MARK = 2;

    // third octal digit codes
    localparam logic [2:0] CODE_ZERO = 3'h0;
    localparam logic [2:0] CODE_TWO = 3'h2;
    localparam logic [2:0] CODE_FOUR = 3'h4;

    // sync vector layout: e bus lines, then trap out, trap in, interrupt
    localparam int SY_TPO = 16;
    localparam int SY_TPI = 17;
    localparam int SY_IRQ = 18;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_P2 = 3'h1, S_P3 = 3'h3, S_P4 = 3'h2,
        S_P5 = 3'h6, S_P6 = 3'h7, S_P7 = 3'h5, S_P8 = 3'h4
    } tis_state_t;

    typedef struct packed {
        tis_state_t st;
        logic [7:0] pcnt;
        logic tick;
        logic clk_en;
        logic [18:0] sy1;
        logic [18:0] sy2;
        logic [18:0] sy3;
        logic [18:0] filt;
        logic dir_out;
        logic icl;
        logic ack;
        logic ack_rel;
        logic tos;
        logic tdo;
        logic drv;
        logic oe;
        logic rcv;
        logic fcy;
        logic trap_in_write;
        logic fry;
        logic dry;
        logic [7:0] dcnt;
        logic [7:0] dry_len;
        logic mstart;
        logic [15:0] wreg;
        logic [14:0] lreg;
        logic [15:0] ebus_out;
        logic [15:0] ctrl;
        logic [14:0] int_addr;
        logic int_taken;
        logic ijmp;
        logic wb_ack;
        logic [31:0] wb_dat;
    } tis_seq_t;

    localparam tis_seq_t SEQ_RESET = '{
        st: S_IDLE, fcy: 1'b1, sy1: '1, sy2: '1, sy3: '1, filt: '1,
        ebus_out: '1, ctrl: CTRL_RESET, int_addr: IADDR_RESET, default: '0
    };

endpackage

// ### hdl/tis_trap_irq_seq.sv
// Purpose: trap (single word transfer) and interrupt sequencer of a minicomputer cpu
// Assumes: 100 MHz clk_i, sync active-high rst_i, active-low cable inputs and e bus, active-high cable flags
// Notes: cpu control levels come in over Wishbone; memory ports are same-clock
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps

module tis_trap_irq_seq
    import tis_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // i/o cable: inputs and e bus data active low, flags and enable active high
    input wire logic trap_out_input_n_i,
    input wire logic trap_in_input_n_i,
    input wire logic interrupt_request_in_n_i,
    input wire logic [15:0] ebus_n_i,
    output logic [15:0] ebus_n_o,
    output logic ebus_oe_o,
    output logic function_ready_o,
    output logic data_ready_strobe_o,
    output logic interrupt_jump_out_o,
    output logic acknowledge_flag_o,
    output logic interrupt_clock_o,
    // cpu and memory side
    input wire logic [15:0] mem_rdata_i,
    output logic first_clock_phase_o,
    output logic mem_start_o,
    output logic full_memory_cycle_o,
    output logic trap_in_write_o,
    output logic [14:0] mem_addr_o,
    output logic [15:0] mem_wdata_o
);

    tis_seq_t s;
    tis_seq_t next_s;
    logic [15:0] abus;
    logic fetch_chk;

    // data output gating, one gate per memory data bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_gate
            logic data_register_bit_n;
            logic gate_n;
            assign data_register_bit_n = ~s.wreg[gi];
            assign gate_n = ~(~data_register_bit_n & s.tdo);
            assign abus[gi] = ~gate_n;
        end
    endgenerate

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    always_comb begin
        logic wr;
        logic rd;
        logic fetch;
        logic tpo;
        logic tpi;
        logic irq;
        logic trap_request;
        logic trap_block;
        logic int_block;
        logic [2:0] code;
        logic [15:0] ebv;
        logic [15:0] c16;
        wr = 1'b0;
        rd = 1'b0;
        fetch = 1'b0;
        c16 = 16'h0000;
        next_s = s;
        next_s.mstart = 1'b0;
        next_s.wb_ack = 1'b0;
        next_s.tick = 1'b0;

        // cable lines: three stages, a change counts once stages two and three agree
        next_s.sy1 = {interrupt_request_in_n_i, trap_in_input_n_i, trap_out_input_n_i,
                      ebus_n_i};
        next_s.sy2 = s.sy1;
        next_s.sy3 = s.sy2;
        next_s.filt = (s.sy2 & s.sy3) | ((s.sy2 ^ s.sy3) & s.filt);
        tpo = ~s.filt[SY_TPO];
        tpi = ~s.filt[SY_TPI];
        irq = ~s.filt[SY_IRQ];
        ebv = ~s.filt[15:0];
        trap_request = tpo | tpi;
        code = s.ctrl[CTL_CODE_LSB +: 3];

        // master period divider
        if (s.pcnt == 8'(PER_CYC - 1)) begin
            next_s.pcnt = 8'h00;
            next_s.tick = 1'b1;
        end else begin
            next_s.pcnt = s.pcnt + 8'h01;
        end
        if (s.clk_en) begin
            next_s.tos = 1'b0;
        end

        // data-ready width counter
        if (s.dry) begin
            next_s.dry_len = s.dry_len + 8'h01;
            next_s.dcnt = s.dcnt - 8'h01;
            if (s.dcnt == 8'h01) begin
                next_s.dry = 1'b0;
            end
        end

        trap_block = (s.ctrl[CTL_HALT] & (code == CODE_ZERO))
                   | s.ctrl[CTL_INCM];

        if (s.tick) begin
            case (s.st)
                S_IDLE: begin
                    if (trap_request && !trap_block && !s.int_taken) begin
                        next_s.st = S_P2;
                        next_s.icl = 1'b1;
                        next_s.ack = 1'b1;
                        next_s.dir_out = tpo;
                        next_s.tos = s.tos | s.ctrl[CTL_SHIFT];
                    end
                end
                S_P2: begin
                    next_s.st = S_P3;
                    next_s.ack_rel = 1'b1;
                end
                S_P3: begin
                    next_s.st = S_P4;
                    next_s.lreg = ebv[14:0];
                    next_s.fry = 1'b1;
                    next_s.mstart = 1'b1;
                    next_s.wreg = 16'h0000;
                end
                S_P4: begin
                    next_s.st = S_P5;
                    next_s.fry = 1'b0;
                    if (s.dir_out) begin
                        next_s.wreg = mem_rdata_i;
                        next_s.tdo = 1'b1;
                        next_s.drv = 1'b1;
                    end else begin
                        next_s.rcv = 1'b1;
                        next_s.fcy = 1'b0;
                    end
                end
                S_P5: begin
                    next_s.st = S_P6;
                    if (!s.dir_out) begin
                        next_s.trap_in_write = 1'b1;
                    end
                end
                S_P6: begin
                    next_s.st = S_P7;
                    next_s.dry = 1'b1;
                    next_s.dry_len = 8'h00;
                    next_s.dcnt = s.dir_out ? 8'(DRY_OUT_CYC) : 8'(DRY_NORM_CYC);
                    if (!s.dir_out) begin
                        next_s.wreg = ebv;
                        next_s.mstart = 1'b1;
                    end
                end
                S_P7: begin
                    next_s.st = S_P8;
                    next_s.ack = ~s.ack_rel;
                    next_s.tdo = 1'b0;
                    next_s.drv = 1'b0;
                    next_s.rcv = 1'b0;
                    next_s.trap_in_write = 1'b0;
                    next_s.fcy = 1'b1;
                end
                S_P8: begin
                    next_s.st = S_IDLE;
                    next_s.icl = 1'b0;
                    next_s.ack_rel = 1'b0;
                end
                default: begin
                    next_s.st = S_IDLE;
                end
            endcase
        end

        // cpu phases stop from the very tick that starts a trap
        next_s.clk_en = s.tick & ~next_s.icl;

        // e bus drive: data registered from the arithmetic bus, enable registered in the same cycle
        next_s.ebus_out = s.drv ? ~abus : 16'hffff;
        next_s.oe = s.drv;

        // wishbone slave, one wait state, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
            next_s.wb_ack = 1'b1;
            wr = wb_we_i;
            rd = ~wb_we_i;
        end
        next_s.wb_dat = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                REG_CTRL: next_s.wb_dat = {16'h0000, s.ctrl};
                REG_STAT: next_s.wb_dat = {21'h000000, irq, trap_request, s.ijmp, s.int_taken,
                                           s.dir_out, s.tos, s.ack, s.icl, s.st};
                REG_LADDR: next_s.wb_dat = {17'h00000, s.lreg};
                REG_WDATA: next_s.wb_dat = {16'h0000, s.wreg};
                REG_IADDR: next_s.wb_dat = {17'h00000, s.int_addr};
                default: next_s.wb_dat = 32'h0000_0000;
            endcase
        end
        if (wr && wb_adr_i == REG_CTRL) begin
            next_s.ctrl = merge16(s.ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
        end
        if (wr && wb_adr_i == REG_IADDR) begin
            c16 = merge16({1'b0, s.int_addr}, wb_dat_i, wb_sel_i);
            next_s.int_addr = c16[14:0];
        end
        fetch = wr && (wb_adr_i == REG_CMD) && wb_sel_i[0] && wb_dat_i[CMD_FETCH];

        // interrupt acceptance and instruction fetch
        int_block = s.ctrl[CTL_EXTC]
                  | s.ctrl[CTL_HALT] | s.ctrl[CTL_STEP]
                  | s.ctrl[CTL_JUMP] | s.ctrl[CTL_IO]
                  | (s.ctrl[CTL_SHIFT] & (code == CODE_FOUR))
                  | s.icl;
        if (fetch) begin
            // a trap starting in this cycle keeps its mark
            if (s.st != S_IDLE || !next_s.icl) begin
                next_s.tos = 1'b0;
            end
            if (s.int_taken && wb_dat_i[CMD_DOUBLE]) begin
                next_s.int_addr = s.int_addr + 15'h0001;
                if (wb_dat_i[CMD_JUMP_AND_MARK] && code == CODE_TWO) begin
                    next_s.ijmp = 1'b1;
                end
            end else begin
                next_s.int_taken = 1'b0;
                next_s.ijmp = 1'b0;
            end
        end
        // the clear wins over a new request in the same cycle; a request still present is taken the cycle after
        if (irq && !int_block && !s.int_taken) begin
            next_s.int_taken = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= SEQ_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.wb_dat;
    assign wb_ack_o = s.wb_ack;
    assign ebus_n_o = s.ebus_out;
    assign ebus_oe_o = s.oe;
    assign function_ready_o = s.fry;
    assign data_ready_strobe_o = s.dry;
    assign interrupt_jump_out_o = s.ijmp;
    assign acknowledge_flag_o = s.ack;
    assign interrupt_clock_o = s.int_taken;
    assign first_clock_phase_o = s.clk_en;
    assign mem_start_o = s.mstart;
    assign full_memory_cycle_o = s.fcy;
    assign trap_in_write_o = s.trap_in_write;
    assign mem_addr_o = s.lreg;
    assign mem_wdata_o = s.wreg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    data_gate_a: assert property (s.tdo |-> abus == s.wreg)
        else $error("arithmetic bus does not carry gated data");
    ebus_drive_a: assert property (ebus_oe_o |-> ebus_n_o == ~s.wreg && s.dir_out)
        else $error("e bus driven with wrong data");
    halt_trap_a: assert property ((s.st == S_IDLE && s.tick && s.ctrl[CTL_HALT]
        && s.ctrl[CTL_CODE_LSB +: 3] == CODE_ZERO) |=> s.st == S_IDLE)
        else $error("trap started while halted");
    incm_trap_a: assert property ((s.st == S_IDLE && s.tick && s.ctrl[CTL_INCM])
        |=> !s.icl)
        else $error("trap started during increment memory");
    int_block_a: assert property ((!s.int_taken && (s.ctrl[CTL_EXTC] || s.ctrl[CTL_IO]
        || s.ctrl[CTL_HALT])) |=> !s.int_taken)
        else $error("interrupt taken while blocked");
    step_block_a: assert property ((!s.int_taken && (s.ctrl[CTL_STEP]
        || s.ctrl[CTL_HALT])) |=> !s.int_taken)
        else $error("interrupt taken while halted or stepping");
    jump_block_a: assert property ((!s.int_taken && (s.ctrl[CTL_JUMP]
        || s.ctrl[CTL_IO])) |=> !s.int_taken)
        else $error("interrupt taken during jump or i/o");
    shift_block_a: assert property ((!s.int_taken && s.ctrl[CTL_SHIFT]
        && s.ctrl[CTL_CODE_LSB +: 3] == CODE_FOUR) |=> !s.int_taken)
        else $error("interrupt taken during shift");
    step_addr_a: assert property ((fetch_chk && s.int_taken && wb_dat_i[CMD_DOUBLE])
        |=> s.int_addr == $past(s.int_addr) + 15'h0001)
        else $error("interrupt address not stepped");
    single_word_a: assert property ((fetch_chk && !wb_dat_i[CMD_DOUBLE])
        |=> s.int_addr == $past(s.int_addr) && !s.ijmp)
        else $error("single-word fetch changed interrupt state");
    jump_code_a: assert property ($rose(s.ijmp)
        |-> $past(s.ctrl[CTL_CODE_LSB +: 3]) == CODE_TWO && $past(s.int_taken))
        else $error("interrupt jump without code two");
    jump_mark_a: assert property ($rose(s.ijmp)
        |-> $past(fetch_chk) && $past(wb_dat_i[CMD_JUMP_AND_MARK]))
        else $error("interrupt jump without jump-and-mark fetch");
    tos_set_a: assert property (($rose(s.icl) && $past(s.ctrl[CTL_SHIFT])) |-> s.tos)
        else $error("trap during shift not recorded");
    tos_clear_a: assert property (s.clk_en |=> !s.tos)
        else $error("trap-on-shift not cleared by first phase");
    phase_stop_a: assert property (s.icl |-> !s.clk_en)
        else $error("first clock phase not inhibited during trap");
    ack_set_a: assert property ($rose(s.ack) |-> $rose(s.icl))
        else $error("acknowledge set outside a trap start");
    ack_order_a: assert property ($fell(s.ack) |-> s.icl ##[1:30] !s.icl)
        else $error("acknowledge not released before inhibit clock");
    trap_source_a: assert property ((s.st == S_IDLE && s.tick && s.filt[SY_TPO]
        && s.filt[SY_TPI]) |=> s.st == S_IDLE)
        else $error("trap started without a request");
    trap_prio_a: assert property ($rose(s.icl)
        |-> s.dir_out == !$past(s.filt[SY_TPO]))
        else $error("trap direction does not favour trap-out");
    addr_take_a: assert property ($rose(s.fry)
        |-> s.lreg == ~$past(s.filt[14:0]))
        else $error("trap address not taken from e bus");
    dry_width_a: assert property ($fell(s.dry) |->
        $past(s.dry_len) == (s.dir_out ? 8'(DRY_OUT_CYC - 1) : 8'(DRY_NORM_CYC - 1)))
        else $error("data ready strobe has wrong width");
    half_write_a: assert property (s.trap_in_write |-> !s.fcy && !s.dir_out && s.rcv)
        else $error("trap-in write outside split cycle");
    split_cycle_a: assert property ((s.st == S_P6 && !s.dir_out) |-> !s.fcy)
        else $error("trap-in memory cycle not split");
    load_start_a: assert property (($rose(s.dry) && !s.dir_out) |-> s.mstart
        && s.wreg == ~$past(s.filt[15:0]))
        else $error("trap-in data not loaded with write start");

    assign fetch_chk = wb_cyc_i && wb_stb_i && !s.wb_ack && wb_we_i
        && wb_adr_i == REG_CMD && wb_sel_i[0] && wb_dat_i[CMD_FETCH];

endmodule

// ### sim/tis_io_ctrl.sv
// Purpose: device controller model that asks for single-word traps
// Assumes: active-low trap request and e bus lines, pulled up while nobody drives them; ready flags active high
// Notes: one trap at a time, started by a go_i pulse
`timescale 1ns/100ps

module tis_io_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic go_i,
    input wire logic dir_in_i,
    input wire logic [14:0] addr_i,
    input wire logic [15:0] data_i,
    output logic [15:0] rx_o,
    output logic done_o,
    // cable
    input wire logic [15:0] ebus_n_i,
    input wire logic function_ready_i,
    input wire logic data_ready_strobe_i,
    output logic trap_out_n_o,
    output logic trap_in_n_o,
    output logic [15:0] drive_n_o
);
    logic busy;
    logic dry_q;
    logic din;

    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy <= 1'b0;
            dry_q <= 1'b0;
            trap_out_n_o <= 1'b1;
            trap_in_n_o <= 1'b1;
            drive_n_o <= 16'hffff;
            rx_o <= 16'h0000;
        end else if (go_i && !busy) begin
            busy <= 1'b1;
            din <= dir_in_i;
            trap_in_n_o <= !dir_in_i;
            trap_out_n_o <= dir_in_i;
            drive_n_o <= ~{1'b0, addr_i};
        end else if (busy) begin
            // address leaves the bus once function ready is seen
            if (function_ready_i) begin
                drive_n_o <= din ? ~data_i : 16'hffff;
            end
            if (data_ready_strobe_i) begin
                dry_q <= 1'b1;
                rx_o <= ~ebus_n_i;
            end else if (dry_q) begin
                // withdraw only after the strobe's trailing edge
                trap_out_n_o <= 1'b1;
                trap_in_n_o <= 1'b1;
                drive_n_o <= 16'hffff;
                busy <= 1'b0;
                dry_q <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule

// ### sim/testbench.sv
// Purpose: self-checking bench for the trap and interrupt sequencer
// Assumes: 100 MHz clock, Wishbone register access, pulled-up e bus
// Notes: memory model is written by the design, expectations by the bench
`timescale 1ns/100ps

module testbench import tis_pkg::*;;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic to_n, ti_n, irq_n, oe, fry, dry, ijo, ackf, iclk, fcp, mst, fcy, tiw, done, go, din;
    logic [15:0] ebus_n_i, ebus_n_o, drv_n, mem_rdata_i, mem_wdata_o, rx, data, q;
    logic [14:0] mem_addr_o, addr;
    int n_fail, checks, cyc, dlen, drun, wr_n, fcy_lo, clash;
    logic ack_seen, wr_q;
    logic [15:0] ram [int];
    int model [int];
    logic [31:0] seed = 32'h2535ec77;

    // released lines float high through the pull-ups
    assign ebus_n_i = drv_n & (oe ? ebus_n_o : 16'hffff);

    tis_trap_irq_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .trap_out_input_n_i(to_n), .trap_in_input_n_i(ti_n),
        .interrupt_request_in_n_i(irq_n), .ebus_n_i(ebus_n_i), .ebus_n_o(ebus_n_o),
        .ebus_oe_o(oe), .function_ready_o(fry), .data_ready_strobe_o(dry),
        .interrupt_jump_out_o(ijo), .acknowledge_flag_o(ackf), .interrupt_clock_o(iclk),
        .mem_rdata_i(mem_rdata_i), .first_clock_phase_o(fcp), .mem_start_o(mst),
        .full_memory_cycle_o(fcy), .trap_in_write_o(tiw), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o));

    tis_io_ctrl ctl_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .dir_in_i(din),
        .addr_i(addr), .data_i(data), .rx_o(rx), .done_o(done), .ebus_n_i(ebus_n_i),
        .function_ready_i(fry), .data_ready_strobe_i(dry), .trap_out_n_o(to_n),
        .trap_in_n_o(ti_n), .drive_n_o(drv_n));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // monitor and memory: reads see what the design last wrote
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 60000) begin
            n_fail++;
            summarize();
        end
        if (dry) drun++;
        else if (drun > 0) begin
            dlen = drun;
            drun = 0;
        end
        if (ackf && fcp) clash++;
        if (ackf) ack_seen = 1'b1;
        if (!fcy) fcy_lo++;
        if (mst && tiw) wr_n++;
        if (wr_q && !tiw) ram[int'(mem_addr_o)] = mem_wdata_o;
        wr_q = tiw;
        mem_rdata_i <= ram.exists(int'(mem_addr_o)) ? ram[int'(mem_addr_o)] : 16'h0;
    end

    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] r);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o[15:0];
        if (n >= 20) check("wb_ack", 0, 1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // blk: ctl must hold the request off until it is cleared
    task automatic trap(input logic i, input logic [14:0] a, input logic [15:0] d,
                        input logic [15:0] ctl, input logic blk);
        int n;
        logic [15:0] e;
        wb(1'b1, REG_CTRL, ctl, q);
        wr_n = 0;
        fcy_lo = 0;
        ack_seen = 1'b0;
        @(posedge clk_i);
        go <= 1'b1;
        din <= i;
        addr <= a;
        data <= d;
        @(posedge clk_i);
        go <= 1'b0;
        if (blk) begin
            repeat (4 * PER_CYC) @(posedge clk_i);
            check("trap_blocked", ack_seen, 0);
            wb(1'b1, REG_CTRL, 16'h0, q);
        end
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        check("trap_done", n < 2000, 1);
        repeat (PER_CYC) @(posedge clk_i);
        check("trap_addr", mem_addr_o, a);
        check("phase_clash", clash, 0);
        if (i) begin
            model[int'(a)] = int'(d);
            check("ram_word", ram[int'(a)], d);
            check("write_starts", wr_n, 1);
            check("half_cycle", fcy_lo > 0, 1);
            check("dry_len", dlen, DRY_NORM_CYC);
        end else begin
            e = model.exists(int'(a)) ? 16'(model[int'(a)]) : 16'h0;
            check("rx_word", rx, e);
            check("no_write", wr_n, 0);
            check("dry_len", dlen, DRY_OUT_CYC);
        end
        if (ctl != 16'h0 && !blk) wb(1'b1, REG_CTRL, 16'h0, q);
    endtask

    int k;
    int n;
    logic [14:0] a;
    logic [15:0] bl [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0040, 16'h0420};

    initial begin
        {rst_i, irq_n} = 2'b11;
        {wb_cyc_i, wb_stb_i, wb_we_i, go, din} = '0;
        {wb_adr_i, wb_dat_i, addr, data} = '0;
        wb_sel_i = 4'h3;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        check("ebus_idle", ebus_n_o, 16'hffff);
        check("full_cycle_idle", fcy, 1);
        wb(1'b0, REG_CTRL, 16'h0, q);
        check("ctrl_reset", q, CTRL_RESET);
        wb(1'b1, REG_CTRL, 16'hffff, q);
        wb(1'b0, REG_CTRL, 16'h0, q);
        check("ctrl_mask", q, CTRL_MASK);
        wb(1'b0, 8'h40, 16'h0, q);
        check("unmapped", q, 16'h0);
        wb(1'b0, REG_IADDR, 16'h0, q);
        check("iaddr_reset", q, {1'b0, IADDR_RESET});
        for (k = 0; k < 4; k++) begin
            a = 15'(xs());
            trap(1'b1, a, 16'(xs()), 16'h0, 1'b0);
            trap(1'b0, a, 16'h0, 16'h0, 1'b0);
        end
        trap(1'b0, a, 16'h0, 16'h0010, 1'b1);
        a = 15'(xs());
        trap(1'b1, a, 16'(xs()), 16'h0001, 1'b1);
        trap(1'b0, a, 16'h0, 16'h0101, 1'b0);
        trap(1'b1, a, 16'(xs()), 16'h0020, 1'b0);
        foreach (bl[j]) begin
            wb(1'b1, REG_CTRL, bl[j], q);
            irq_n <= 1'b0;
            repeat (2 * PER_CYC) @(posedge clk_i);
            check("irq_blocked", iclk, 0);
            irq_n <= 1'b1;
        end
        wb(1'b1, REG_CTRL, 16'h0200, q);
        irq_n <= 1'b0;
        n = 0;
        while (iclk !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check("irq_taken", iclk, 1);
        irq_n <= 1'b1;
        repeat (5) @(posedge clk_i);
        a = 15'(xs());
        wb(1'b1, REG_IADDR, {1'b0, a}, q);
        wb(1'b1, REG_CMD, 16'h0007, q);
        wb(1'b0, REG_IADDR, 16'h0, q);
        check("iaddr_step", q, {1'b0, a + 15'h1});
        check("jump_out", ijo, 1);
        wb(1'b1, REG_CMD, 16'h0001, q);
        repeat (2) @(posedge clk_i);
        check("irq_cleared", iclk, 0);
        summarize();
    end
endmodule
